// *** rtl/psrw_bridge.sv ***
// Program space read window bridge between core data reads and flash
`timescale 1ns/100ps
`default_nettype none
// Contract
// - The upper 32 Kbytes of data space can map onto any 16K-word program page for reads.
// - A read is redirected only when the address top bit and page bit 9 are both one.
// - Program address is the low 8 page bits joined above pointer bits 14 to 0.
// - Page bit 8 picks the lower word when zero and the upper word when one.
// - There are 512 window pages numbered 200h through 3FFh of 16K words each.
// - Pages 200h to 2FFh give lower words and 300h to 3FFh give upper words.
// - The window is read-only and lower pages cover the low words of all program words.
// - An upper-half access with a zero page raises an address error trap instead.
// - Outside a loop, move and double move through the window take one extra cycle.
// - Outside a loop, other window reads take two extra cycles.
// - In a loop, first, last, interrupt exit and re-entry iterations take two extra.
// - Other loop iterations through the window complete in one cycle.
// - The window reaches only user program memory, never configuration memory.
module psrw_bridge
	import psrw_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic req,
	input wire logic req_write,
	input wire logic [DATA_AW-1:0] effective_address,
	input wire logic is_move,
	input wire logic in_repeat,
	input wire logic rpt_first,
	input wire logic rpt_last,
	input wire logic rpt_irq_exit,
	input wire logic rpt_irq_reentry,
	input wire logic [PAGE_W-1:0] read_page_select,
	input wire logic [PAGE_W-1:0] write_page_select,
	input wire logic [15:0] ram_rdata,
	input wire logic [23:0] flash_rdata,
	output logic ram_req_ff,
	output logic ram_we_ff,
	output logic [DATA_AW-1:0] ram_addr_ff,
	output logic flash_req_ff,
	output logic [PROG_AW-1:0] flash_addr_ff,
	output logic stall_ff,
	output logic done_ff,
	output logic [15:0] rdata_ff,
	output logic addr_trap_ff
);
	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	logic [1:0] extra;
	logic upper_half;
	logic [PAGE_W-1:0] page_sel;
	logic win_hit;
	logic trap_hit;
	psrw_state_t state_ff, nxt_state;
	logic [1:0] cnt_ff, nxt_cnt;
	logic half_ff, nxt_half;
	logic win_ff, nxt_win;
	// Next values of the registered outputs
	logic nxt_ram_req, nxt_ram_we, nxt_flash_req, nxt_stall, nxt_done, nxt_trap;
	logic [DATA_AW-1:0] nxt_ram_addr;
	logic [PROG_AW-1:0] nxt_flash_addr;
	logic [15:0] nxt_rdata;

	psrw_stall_calc u_calc (
		.is_move(is_move),
		.in_repeat(in_repeat),
		.rpt_first(rpt_first),
		.rpt_last(rpt_last),
		.rpt_irq_exit(rpt_irq_exit),
		.rpt_irq_reentry(rpt_irq_reentry),
		.extra(extra)
	);

	// Upper data half and page selection per direction
	always_comb begin
		upper_half = effective_address[EA_MSB];
		page_sel = req_write ? write_page_select : read_page_select;
		// zero page in upper half traps
		trap_hit = upper_half && (page_sel == PAGE_NONE);
		// both top bits needed; writes never redirect
		win_hit = upper_half && !req_write && read_page_select[PAGE_ENABLE_BIT];
	end

	// ----------------------------------------
	// Access sequencing
	// ----------------------------------------
	// Flash read is issued at once; stall cycles only hold the core
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_half = half_ff;
		nxt_win = win_ff;
		nxt_ram_req = 1'h0;
		nxt_ram_we = 1'h0;
		nxt_ram_addr = ram_addr_ff;
		nxt_flash_req = 1'h0;
		nxt_flash_addr = flash_addr_ff;
		nxt_stall = 1'h0;
		nxt_done = 1'h0;
		nxt_trap = 1'h0;
		nxt_rdata = rdata_ff;
		unique case (state_ff)
			// Requests are only taken here; busy states ignore req
			PSRW_IDLE: begin
				if (req) begin
					if (trap_hit) begin
						nxt_trap = 1'h1;
						nxt_done = 1'h1;
					end else if (win_hit) begin
						// page low bits over offset; bit 23 stays zero
						nxt_flash_req = 1'h1;
						nxt_flash_addr = {read_page_select[PAGE_LOW_W-1:0],
							effective_address[OFFSET_W-1:0]};
						// page bit 8 picks word half
						nxt_half = read_page_select[PAGE_HALF_BIT];
						nxt_win = 1'h1;
						nxt_cnt = extra;
						nxt_stall = 1'h1;
						nxt_state = PSRW_STALL;
					end else begin
						nxt_ram_req = 1'h1;
						nxt_ram_we = req_write;
						nxt_ram_addr = effective_address;
						nxt_win = 1'h0;
						nxt_cnt = EXTRA_NONE;
						nxt_stall = 1'h1;
						nxt_state = PSRW_STALL;
					end
				end
			end
			// Memories answer in the last stall cycle, counted or not
			PSRW_STALL: begin
				if (cnt_ff == EXTRA_NONE) begin
					// no extra cycle when count is zero
					nxt_done = 1'h1;
					if (win_ff) begin
						// upper byte of high word reads zero
						nxt_rdata = half_ff ? {8'h00, flash_rdata[23:16]} : flash_rdata[15:0];
					end else begin
						nxt_rdata = ram_rdata;
					end
					nxt_state = PSRW_DONE;
				end else begin
					// hold core for each extra cycle
					nxt_stall = 1'h1;
					nxt_cnt = cnt_ff - 2'h1;
				end
			end
			// One dead cycle so a held req is not taken twice
			PSRW_DONE: begin
				nxt_state = PSRW_IDLE;
			end
			// Unused code falls back to idle
			default: begin
				nxt_state = PSRW_IDLE;
			end
		endcase
	end

	// Registered outputs; async reset leaves no access half done
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= PSRW_IDLE;
			cnt_ff <= EXTRA_NONE;
			half_ff <= 1'h0;
			win_ff <= 1'h0;
			ram_req_ff <= 1'h0;
			ram_we_ff <= 1'h0;
			ram_addr_ff <= '0;
			flash_req_ff <= 1'h0;
			flash_addr_ff <= '0;
			stall_ff <= 1'h0;
			done_ff <= 1'h0;
			rdata_ff <= 16'h0000;
			addr_trap_ff <= 1'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			half_ff <= nxt_half;
			win_ff <= nxt_win;
			ram_req_ff <= nxt_ram_req;
			ram_we_ff <= nxt_ram_we;
			ram_addr_ff <= nxt_ram_addr;
			flash_req_ff <= nxt_flash_req;
			flash_addr_ff <= nxt_flash_addr;
			stall_ff <= nxt_stall;
			done_ff <= nxt_done;
			rdata_ff <= nxt_rdata;
			addr_trap_ff <= nxt_trap;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_window_redirect: assert property (
		(state_ff == PSRW_IDLE && req && win_hit && !trap_hit) |=> flash_req_ff)
		else $error("window read not redirected");
	chk_plain_access: assert property (
		(state_ff == PSRW_IDLE && req && !upper_half) |=> ram_req_ff && !flash_req_ff)
		else $error("lower half read redirected");
	chk_addr_form: assert property (
		(state_ff == PSRW_IDLE && req && win_hit && !trap_hit) |=>
		flash_addr_ff == {$past(read_page_select[7:0]), $past(effective_address[14:0])})
		else $error("program address malformed");
	chk_trap_zero: assert property (
		(state_ff == PSRW_IDLE && req && trap_hit) |=> addr_trap_ff && !flash_req_ff && !ram_req_ff)
		else $error("zero page did not trap");
	chk_no_write_win: assert property (
		flash_req_ff |-> !$past(req_write))
		else $error("write reached flash");
	chk_move_extra: assert property (
		(state_ff == PSRW_IDLE && req && win_hit && !trap_hit && is_move && !in_repeat)
		|=> stall_ff ##1 stall_ff ##1 done_ff)
		else $error("move stall not one extra");
	chk_other_extra: assert property (
		(state_ff == PSRW_IDLE && req && win_hit && !trap_hit && !is_move && !in_repeat)
		|=> stall_ff [*3] ##1 done_ff)
		else $error("other stall not two extra");
	chk_loop_steady: assert property (
		(state_ff == PSRW_IDLE && req && win_hit && !trap_hit && in_repeat && !rpt_first
		&& !rpt_last && !rpt_irq_exit && !rpt_irq_reentry) |=> stall_ff ##1 done_ff)
		else $error("steady loop read stalled");
	chk_loop_edge: assert property (
		(state_ff == PSRW_IDLE && req && win_hit && !trap_hit && in_repeat && rpt_first)
		|=> stall_ff [*3] ##1 done_ff)
		else $error("loop edge stall wrong");
	chk_upper_zero: assert property (
		(done_ff && win_ff && half_ff) |-> rdata_ff[15:8] == 8'h00)
		else $error("phantom byte not zero");
	// Both word halves come from the flash word sampled one cycle earlier
	chk_low_word: assert property (
		(done_ff && win_ff && !half_ff) |-> rdata_ff == $past(flash_rdata[15:0]))
		else $error("lower program word wrong");
	chk_high_word: assert property (
		(done_ff && win_ff && half_ff) |-> rdata_ff[7:0] == $past(flash_rdata[23:16]))
		else $error("upper program byte wrong");
	chk_half_select: assert property (
		(state_ff == PSRW_IDLE && req && win_hit && !trap_hit) |=>
		half_ff == $past(read_page_select[PAGE_HALF_BIT]))
		else $error("word half not from page bit");
	// A redirected read always came from a page of the window range
	chk_page_range: assert property (
		flash_req_ff |-> $past(read_page_select) >= PAGE_FIRST)
		else $error("flash read outside window pages");
	// Ordinary reads hand back the data word unchanged
	chk_ram_data: assert property (
		(done_ff && !win_ff && !addr_trap_ff) |-> rdata_ff == $past(ram_rdata))
		else $error("data word not returned");
	// Ordinary accesses pass the address through and take two cycles
	chk_ram_addr: assert property (
		(state_ff == PSRW_IDLE && req && !trap_hit && !win_hit) |=>
		ram_addr_ff == $past(effective_address))
		else $error("data address altered");
	chk_ram_latency: assert property (
		(state_ff == PSRW_IDLE && req && !trap_hit && !win_hit) |=> stall_ff ##1 done_ff)
		else $error("data access latency wrong");
	// Writes never touch flash, whatever the read page says
	chk_write_plain: assert property (
		(state_ff == PSRW_IDLE && req && req_write && !trap_hit) |=> ram_req_ff && ram_we_ff)
		else $error("write not sent to data space");
	// The later loop edges cost as much as the first one
	chk_loop_exit: assert property (
		(state_ff == PSRW_IDLE && req && win_hit && !trap_hit && in_repeat
		&& (rpt_last || rpt_irq_exit || rpt_irq_reentry)) |=> stall_ff [*3] ##1 done_ff)
		else $error("loop exit stall wrong");
	// A trap ends the access at once without holding the core
	chk_trap_done: assert property (
		addr_trap_ff |-> done_ff && !stall_ff)
		else $error("trap did not end access");
	// The lower data half can never trap, whatever the pages hold
	chk_no_trap_lower: assert property (
		(state_ff == PSRW_IDLE && req && !upper_half) |=> !addr_trap_ff)
		else $error("lower half access trapped");
	// Busy states start nothing, so a held request costs no second access
	chk_busy_refused: assert property (
		(state_ff != PSRW_IDLE) |=> !ram_req_ff && !flash_req_ff && !addr_trap_ff)
		else $error("request taken while busy");
	chk_done_pulse: assert property (
		done_ff |=> !done_ff)
		else $error("done held over two cycles");

	// ----------------------------------------
	// Scenario covers
	// ----------------------------------------
	cov_window_low: cover property (done_ff && win_ff && !half_ff);
	cov_window_high: cover property (done_ff && win_ff && half_ff);
	cov_trap: cover property (addr_trap_ff);
	cov_ram: cover property (done_ff && !win_ff);
	cov_loop_steady: cover property (state_ff == PSRW_IDLE && req && win_hit && in_repeat
		&& !rpt_first && !rpt_last && !rpt_irq_exit && !rpt_irq_reentry);
endmodule
`default_nettype wire

// *** rtl/psrw_pkg.sv ***
// Constants for the program space read window bridge
package psrw_pkg;
	// ----------------------------------------
	// Address and page layout
	// ----------------------------------------
	localparam int DATA_AW = 16;
	localparam int PROG_AW = 23;
	localparam int PAGE_W = 10;
	localparam int PAGE_ENABLE_BIT = 9;
	localparam int PAGE_HALF_BIT = 8;
	localparam int PAGE_LOW_W = 8;
	localparam int OFFSET_W = 15;
	localparam int EA_MSB = 15;
	localparam logic [9:0] PAGE_FIRST = 10'h200;
	localparam logic [9:0] PAGE_LOW_LAST = 10'h2ff;
	localparam logic [9:0] PAGE_HIGH_FIRST = 10'h300;
	localparam logic [9:0] PAGE_LAST = 10'h3ff;
	localparam logic [9:0] PAGE_NONE = 10'h000;
	localparam logic [9:0] PAGE_RESET = 10'h000;
	// ----------------------------------------
	// Stall counts in instruction cycles
	// ----------------------------------------
	localparam logic [1:0] EXTRA_MOVE = 2'h1;
	localparam logic [1:0] EXTRA_OTHER = 2'h2;
	localparam logic [1:0] EXTRA_NONE = 2'h0;
	// Access sequencing
	typedef enum logic [1:0] {PSRW_IDLE, PSRW_STALL, PSRW_DONE} psrw_state_t;
endpackage

// *** rtl/psrw_stall_calc.sv ***
// Extra cycle count for one window read
`timescale 1ns/100ps
`default_nettype none
module psrw_stall_calc
	import psrw_pkg::*;
(
	input wire logic is_move,
	input wire logic in_repeat,
	input wire logic rpt_first,
	input wire logic rpt_last,
	input wire logic rpt_irq_exit,
	input wire logic rpt_irq_reentry,
	output logic [1:0] extra
);
	// ----------------------------------------
	// Count selection
	// ----------------------------------------
	// Edge iterations of a loop pay full cost; steady ones pipeline
	always_comb begin
		if (in_repeat) begin
			if (rpt_first || rpt_last || rpt_irq_exit || rpt_irq_reentry) begin
				extra = EXTRA_OTHER;
			end else begin
				extra = EXTRA_NONE;
			end
		end else if (is_move) begin
			extra = EXTRA_MOVE;
		end else begin
			extra = EXTRA_OTHER;
		end
	end
endmodule
`default_nettype wire

// *** test/psrw_mem_model.sv ***
// Far-side memory model: data RAM and program flash answering the bridge
`timescale 1ns/100ps
`default_nettype none
module psrw_mem_model
	import psrw_pkg::*;
(
	input wire logic [DATA_AW-1:0] ram_addr,
	input wire logic [PROG_AW-1:0] flash_addr,
	output logic [15:0] ram_rdata,
	output logic [23:0] flash_rdata
);
	// Address-derived words, so a wrong RAM address or wrong flash address bits 15 to 0 show up as wrong data
	assign ram_rdata = ram_addr ^ 16'hc0de;
	assign flash_rdata = {flash_addr[7:0] ^ 8'ha5, flash_addr[15:0] ^ 16'h1234};
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the program space read window bridge
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import psrw_pkg::*;
;
	typedef struct packed {
		logic wr;
		logic [15:0] ea;
		logic mv;
		logic [4:0] rpt;
		logic [9:0] rp;
		logic [9:0] wp;
		logic trap;
		logic fl;
		logic [2:0] lat;
	} psrw_row_t;
	logic clk = 1'b0, nrst = 1'b0, req = 1'b0, wr = 1'b0, mv = 1'b0;
	logic [15:0] ea = 16'h0000;
	logic [4:0] rpt = 5'h00;
	logic [9:0] rp = 10'h000, wp = 10'h000;
	logic ram_req, ram_we, flash_req, stall, done, trap;
	logic [15:0] ram_addr, rdata, ram_rdata;
	logic [22:0] flash_addr;
	logic [23:0] flash_rdata;
	int error_cnt = 0, checks_done = 0;
	// Rows: wr, address, move, repeat context, pages, trap, redirect, latency
	psrw_row_t rows [14] = '{
		'{1'h0, 16'h800a, 1'h1, 5'h00, 10'h202, 10'h000, 1'h0, 1'h1, 3'h3},
		'{1'h0, 16'hffff, 1'h0, 5'h00, 10'h3ff, 10'h000, 1'h0, 1'h1, 3'h4},
		'{1'h0, 16'hc123, 1'h0, 5'h00, 10'h200, 10'h000, 1'h0, 1'h1, 3'h4},
		'{1'h0, 16'h8000, 1'h1, 5'h00, 10'h300, 10'h000, 1'h0, 1'h1, 3'h3},
		'{1'h0, 16'h9abc, 1'h1, 5'h10, 10'h2ff, 10'h000, 1'h0, 1'h1, 3'h2},
		'{1'h0, 16'h9abc, 1'h1, 5'h18, 10'h2ff, 10'h000, 1'h0, 1'h1, 3'h4},
		'{1'h0, 16'h9abc, 1'h1, 5'h14, 10'h2ff, 10'h000, 1'h0, 1'h1, 3'h4},
		'{1'h0, 16'h9abc, 1'h1, 5'h12, 10'h2ff, 10'h000, 1'h0, 1'h1, 3'h4},
		'{1'h0, 16'h9abc, 1'h1, 5'h11, 10'h2ff, 10'h000, 1'h0, 1'h1, 3'h4},
		'{1'h0, 16'h7fff, 1'h0, 5'h00, 10'h3ff, 10'h000, 1'h0, 1'h0, 3'h2},
		'{1'h0, 16'h9000, 1'h0, 5'h00, 10'h1ff, 10'h000, 1'h0, 1'h0, 3'h2},
		'{1'h0, 16'h8000, 1'h0, 5'h00, 10'h000, 10'h3ff, 1'h1, 1'h0, 3'h1},
		'{1'h1, 16'hffff, 1'h0, 5'h00, 10'h3ff, 10'h000, 1'h1, 1'h0, 3'h1},
		'{1'h1, 16'h8002, 1'h0, 5'h00, 10'h3ff, 10'h201, 1'h0, 1'h0, 3'h2}
	};

	// 25 MHz instruction clock
	always #20 clk = ~clk;

	psrw_bridge DUT (.clk(clk), .nrst(nrst), .req(req), .req_write(wr),
		.effective_address(ea), .is_move(mv), .in_repeat(rpt[4]), .rpt_first(rpt[3]),
		.rpt_last(rpt[2]), .rpt_irq_exit(rpt[1]), .rpt_irq_reentry(rpt[0]),
		.read_page_select(rp), .write_page_select(wp), .ram_rdata(ram_rdata),
		.flash_rdata(flash_rdata), .ram_req_ff(ram_req), .ram_we_ff(ram_we),
		.ram_addr_ff(ram_addr), .flash_req_ff(flash_req), .flash_addr_ff(flash_addr),
		.stall_ff(stall), .done_ff(done), .rdata_ff(rdata), .addr_trap_ff(trap));

	psrw_mem_model mem (.ram_addr(ram_addr), .flash_addr(flash_addr),
		.ram_rdata(ram_rdata), .flash_rdata(flash_rdata));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Request launched just after an edge, taken at the next one
	task automatic start(input psrw_row_t r);
		@(posedge clk);
		req <= 1'b1;
		wr <= r.wr;
		ea <= r.ea;
		mv <= r.mv;
		rpt <= r.rpt;
		rp <= r.rp;
		wp <= r.wp;
	endtask

	task automatic run(input psrw_row_t r);
		int n;
		logic sf, sr, st, we;
		logic [22:0] pa;
		logic [23:0] fw;
		n = 0;
		sf = 1'b0;
		sr = 1'b0;
		st = 1'b0;
		we = 1'b0;
		pa = {r.rp[7:0], r.ea[14:0]};
		fw = {pa[7:0] ^ 8'ha5, pa[15:0] ^ 16'h1234};
		start(r);
		// Bounded wait for completion, noting every pulse seen
		do begin
			@(posedge clk);
			req <= 1'b0;
			#1;
			n++;
			if (flash_req === 1'b1) sf = 1'b1;
			if (trap === 1'b1) st = 1'b1;
			if (ram_req === 1'b1) begin
				sr = 1'b1;
				we = ram_we;
			end
			if (n == 1 && r.lat > 1) chk(stall === 1'b1, "no stall");
		end while (done !== 1'b1 && n < 8);
		chk(n == r.lat, "latency");
		chk(stall === 1'b0, "stall at done");
		chk(st === r.trap, "trap");
		chk(sf === r.fl, "redirect");
		chk(sr === (!r.trap && !r.fl), "ram access");
		if (r.fl) begin
			chk(flash_addr === pa, "program address");
			chk(rdata === (r.rp[8] ? {8'h00, fw[23:16]} : fw[15:0]), "word half");
		end
		if (sr) begin
			chk(ram_addr === r.ea && we === r.wr, "ram addr");
			if (!r.wr) chk(rdata === (r.ea ^ 16'hc0de), "ram data");
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int k;
		repeat (6) @(posedge clk);
		chk({done, stall, trap, flash_req, ram_req} === 5'h00, "reset outputs");
		nrst <= 1'b1;
		foreach (rows[i]) run(rows[i]);
		// Request held while busy must not start a second access
		k = 0;
		start(rows[1]);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			// Held through the stall cycles and the dead cycle after done
			if (i == 4) req <= 1'b0;
			#1;
			if (done === 1'b1) k++;
		end
		chk(k == 1, "busy request taken");
		// Reset in mid-access clears everything, then traffic resumes
		start(rows[1]);
		@(posedge clk);
		req <= 1'b0;
		// Reset lands in the stall phase of the access
		@(posedge clk);
		nrst <= 1'b0;
		#1;
		chk({done, stall, flash_req} === 3'h0, "mid reset");
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		run(rows[0]);
		conclude();
	end

	// Watchdog well beyond the 80 or so cycles the tests need
	initial begin
		#40000;
		error_cnt++;
		$display("[ERR] %0t watchdog", $time);
		conclude();
	end
endmodule
`default_nettype wire
